// [dv/ctm_pin_src.sv]
// Purpose: Pin and timer source standing outside the aux block
// Assumes: Pins change only on request from the bench
// Notes:   Toggled pins hold for many clocks, wider than the synchronisers
`timescale 1ns/10ps
module ctm_pin_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  flip_i,
  output logic      [7:0]  pin_o,
  output logic      [15:0] timer_o,
  output logic             tick_o
);
  // Free timer and held pin levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o   <= 8'h00;
      timer_o <= 16'h0000;
    end else begin
      pin_o   <= pin_o ^ flip_i;
      timer_o <= timer_o + 16'h0001;
    end
  end
  // Gate tick once every 64 clocks
  assign tick_o = (timer_o[5:0] == 6'h00);
endmodule

// [dv/tb.sv]
// Purpose: Register-level bench for the aux counters block
// Assumes: One access at a time; ack is awaited under a bound
// Notes:   Expected values come from the register layout only
`timescale 1ns/10ps
module tb;
  import ctm_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, tick, irq, nm;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [7:0]  pins, flip, ev;
  logic [3:0]  cflags;
  logic [15:0] tmr, h;
  ctm_modctl_t mctl;
  int          n_errors, total_checks, n_ev5;

  ctm_pin_src ctm_pin_src_inst (.clk_i(clk_i), .rst_i(rst_i), .flip_i(flip), .pin_o(pins),
    .timer_o(tmr), .tick_o(tick));
  ctm_aux ctm_aux_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .ch_pin_i(pins), .timer_i(tmr), .gate_tick_i(tick),
    .normal_mode_i(nm), .capture_event_o(ev), .capture_flags_o(cflags),
    .underflow_irq_o(irq), .mod_ctl_o(mctl));

  // Counts channel 5 pulses; only sharing from channel 1 can raise them here
  always @(posedge clk_i) begin
    if (rst_i) begin
      n_ev5 <= 0;
    end else if (ev[5] === 1'b1) begin
      n_ev5 <= n_ev5 + 1;
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    n_errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) bad(m);
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      bad("bus timeout");
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] e, input string m);
    wb(1'b0, idx, 16'h0000);
    chk(q[15:0], e, m);
  endtask
  // Polls the underflow flag; a hang here ends the run
  task automatic wait_uf;
    int n;
    n = 0;
    q = '0;
    while (q[7] !== 1'b1) begin
      wb(1'b0, IDX_MOD_FLAGS, 16'h0000);
      n++;
      if (n > 50) begin
        bad("no underflow");
        wrap_up();
      end
    end
  endtask
  task automatic pin_edge(input logic [7:0] m);
    flip <= m;
    @(posedge clk_i);
    flip <= 8'h00;
    repeat (12) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, flip} = {1'b1, 53'h0};
    nm = 1'b1;
    sel_i = 4'h3;
    n_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(IDX_MOD_COUNT, MOD_PRESET, "mod count reset");
    rd(IDX_ACC_A_FLAGS, 16'h0000, "A flags reset");
    rd(8'h10, 16'h0000, "unmapped read");
    $display("test reset done");
    wb(1'b1, IDX_AUX_CTL, 16'h0016);
    wb(1'b1, IDX_ACC_A_PAIR, 16'hffff);
    wb(1'b1, IDX_ACC_B_PAIR, 16'hffff);
    rd(IDX_ACC_A_PAIR, 16'hffff, "A pair word");
    pin_edge(8'h81);
    rd(IDX_ACC_A_PAIR, 16'h0000, "A pair wrap");
    rd(IDX_ACC_A_FLAGS, 16'h0003, "A flags set");
    rd(IDX_ACC_B_FLAGS, 16'h0002, "B overflow");
    wb(1'b1, IDX_ACC_A_FLAGS, 16'h0002);
    rd(IDX_ACC_A_FLAGS, 16'h0001, "A ovf clear");
    wb(1'b1, IDX_AUX_CTL, 16'h0013);
    rd(IDX_ACC_A_PAIR, 16'h0000, "A pair held");
    rd(IDX_ACC_A_FLAGS, 16'h0000, "fast clear");
    $display("test accumulators done");
    // Enable first; force load acts only while the counter is enabled
    wb(1'b1, IDX_MOD_CTL, 16'h0004);
    wb(1'b1, IDX_MOD_COUNT, 16'h0003);
    wb(1'b1, IDX_MOD_CTL, 16'h008c);
    wait_uf();
    chk({15'h0000, irq}, 16'h0001, "irq on");
    wb(1'b1, IDX_MOD_FLAGS, 16'h0080);
    chk({15'h0000, irq}, 16'h0000, "irq off");
    rd(IDX_MOD_COUNT, 16'h0000, "one shot stop");
    wb(1'b1, IDX_MOD_CTL, 16'h00b4);
    rd(IDX_MOD_COUNT, 16'h0003, "load reg read");
    rd(IDX_MOD_CTL, 16'h00a4, "force bits read 0");
    chk({8'h00, mctl}, 16'h00a4, "control copy");
    wb(1'b1, IDX_MOD_CTL, 16'h0000);
    rd(IDX_MOD_COUNT, MOD_PRESET, "disabled preset");
    wb(1'b1, IDX_MOD_CTL, 16'h0044);
    wb(1'b1, IDX_MOD_COUNT, 16'h0002);
    wb(1'b1, IDX_MOD_CTL, 16'h004c);
    wait_uf();
    wb(1'b1, IDX_MOD_FLAGS, 16'h0080);
    wait_uf();
    $display("test modulus done");
    // Queue mode, channel 1 shared onto 5; second write refused until special mode
    wb(1'b1, IDX_CAP_SYS_CTL, 16'h0022);
    wb(1'b1, IDX_CAP_SYS_CTL, 16'h0000);
    rd(IDX_CAP_SYS_CTL, 16'h0022, "second write refused");
    nm <= 1'b0;
    wb(1'b1, IDX_CAP_SYS_CTL, 16'h002a);
    rd(IDX_CAP_SYS_CTL, 16'h002a, "special mode write");
    wb(1'b1, IDX_CAP_FLAGS, 16'h000f);
    pin_edge(8'h02);
    chk({12'h000, cflags}, 16'h0000, "no flag before transfer");
    pin_edge(8'h02);
    chk({12'h000, cflags}, 16'h0002, "flag on transfer");
    wb(1'b0, IDX_MOD_FLAGS, 16'h0000);
    chk({12'h000, q[3:0]}, 16'h0003, "first edge polarity");
    // Edges were launched 13 clocks apart, so the timer values differ by 13
    wb(1'b0, IDX_HOLD0 + 8'h01, 16'h0000);
    h = q[15:0];
    wb(1'b0, IDX_CAPTURE0 + 8'h01, 16'h0000);
    chk(q[15:0] - h, 16'h000d, "queue order");
    $display("test capture done");
    // Channel 0 steps and stays; channel 1 pulse returns inside the delay
    wb(1'b1, IDX_CAP_FLAGS, 16'h000f);
    wb(1'b1, IDX_DELAY_CTL, 16'h0001);
    pin_edge(8'h03);
    pin_edge(8'h02);
    repeat (300) @(posedge clk_i);
    chk({12'h000, cflags}, 16'h0001, "delay filter");
    chk(16'(n_ev5), 16'h0002, "shared events");
    $display("test delay done");
    wrap_up();
  end
endmodule

// [hw/ctm_aux.sv]
// Purpose: Pulse accumulators, modulus down-counter, edge delay filter and buffered
//          capture channels 0..3 of a 16-bit capture timer, on classic Wishbone
// Assumes: Pins are asynchronous; timer_i and gate_tick_i come from the same clock
// Notes:   Captures take either edge after filtering; all side effects act at request
//
// Overview of operation
// RQ1: Fast-clear set: any accumulator A count access clears both A flags.
// RQ2: A overflow sets on 16-bit wrap or accumulator 3 wrap; write bit 1 clears.
// RQ3: A input flag sets on selected channel-7 edge or trailing gate edge; bit 0 clears.
// RQ4: A system enable cascades accumulators 3 (high) and 2 (low) into 16 bits.
// RQ5: A 16-bit accumulator count is read or written whole in one access.
// RQ6: B system enable cascades accumulators 1 and 0; accumulator 1 wrap sets B overflow.
// RQ7: Without reload mode count once and stop at zero; with it reload latest value.
// RQ8: Software should disable the down-counter before changing reload mode.
// RQ9: Read-load select chooses live count or load register on count reads.
// RQ10: Force latch in latch mode copies captures and accumulators, clears accumulators.
// RQ11: Force load while enabled copies load into count and resets prescaler.
// RQ12: While the down-counter is disabled its count is held at FFFF.
// RQ13: Prescale codes divide by 1, 4, 8, 16; new rate applies at next load.
// RQ14: Underflow flag bit 7 sets at zero, drives interrupt, write-1 or fast-clear clears.
// RQ15: Polarity bits record edge of first capture after the holding register read.
// RQ16: Individual byte enables act only while their system enable is clear.
// RQ17: Delay filter waits 256, 512 or 1024 clocks, forwards only an opposite level.
// RQ18: No-overwrite keeps capture or holding register until it is emptied.
// RQ19: Capture system register takes one write in normal mode, any in special mode.
// RQ20: Channel share lets pin x and its detector also drive channel x+4.
// RQ21: Flag timing mode in queue mode sets capture flags only on holding transfer.
// RQ22: Queue mode moves the old capture to holding before storing the new one.
// RQ23: All registers reset to zero except the modulus count at FFFF.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module ctm_aux (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  ch_pin_i,
  input  wire logic [15:0] timer_i,
  input  wire logic        gate_tick_i,
  input  wire logic        normal_mode_i,
  output logic      [7:0]  capture_event_o,
  output logic      [3:0]  capture_flags_o,
  output logic             underflow_irq_o,
  output ctm_pkg::ctm_modctl_t mod_ctl_o
);
  import ctm_pkg::*;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [4:0] div_rate(input logic [1:0] code);
    div_rate = (code == 2'b00) ? DIV_CODE_0 : (code == 2'b01) ? DIV_CODE_1 :
               (code == 2'b10) ? DIV_CODE_2 : DIV_CODE_3;
  endfunction

  function automatic logic [10:0] dly_len(input logic [1:0] code);
    dly_len = (code == 2'b01) ? DLY_CYC_1 : (code == 2'b10) ? DLY_CYC_2 : DLY_CYC_3;
  endfunction

  ctm_modctl_t mctl_ff;
  ctm_capsys_t csys_ff;
  logic [7:0]  auxctl_ff, acc_en_ff, novw_ff;
  logic [1:0]  dly_sel_ff;
  logic        sys_written_ff, ack_ff;
  logic [7:0]  sync1_ff, sync2_ff, prev_ff;
  logic [10:0] dcnt_ff [8];
  logic [7:0]  dbusy_ff, dlvl_ff, fevt_ff, fpol_ff;
  logic [7:0]  pac_ff [4];
  logic [7:0]  nxt_pac [4];
  logic [7:0]  pach_ff [4];
  logic [15:0] cap_ff [4];
  logic [15:0] hold_ff [4];
  logic [3:0]  cap_full_ff, hold_full_ff, pol_ff, pol_arm_ff, cflag_ff;
  logic [15:0] mcnt_ff, mload_ff;
  logic [3:0]  pcnt_ff;
  logic [4:0]  rate_ff;
  logic        a_ovf_ff, a_in_ff, b_ovf_ff, uflag_ff;
  logic [31:0] rdata_ff;

  // Request decode; effects act once per transfer, on the cycle before ack
  wire        req      = cyc_i & stb_i & ~ack_ff;
  wire [7:0]  idx      = adr_i[9:2];
  wire        wr       = req & we_i;
  wire        rd       = req & ~we_i;
  wire        wr_b0    = wr & sel_i[0];
  wire        fast_clr = auxctl_ff[BIT_FAST_CLR];
  wire        a_en     = auxctl_ff[BIT_A_ENABLE];
  wire        b_en     = auxctl_ff[BIT_B_ENABLE];
  wire        a_gated  = auxctl_ff[BIT_A_GATED];
  wire        a_edge   = auxctl_ff[BIT_A_EDGE];
  wire        queue_md = csys_ff.holding_buffer_enable & ~csys_ff.latch_or_queue_select;
  wire        latch_md = csys_ff.holding_buffer_enable & csys_ff.latch_or_queue_select;
  wire        acc_a_hit = req & (idx == IDX_ACC3_COUNT || idx == IDX_ACC2_COUNT ||
                                 idx == IDX_ACC_A_PAIR);
  wire        acc_b_hit = req & (idx == IDX_ACC1_COUNT || idx == IDX_ACC0_COUNT ||
                                 idx == IDX_ACC_B_PAIR);
  wire        mcnt_hit  = req & (idx == IDX_MOD_COUNT);
  wire        mcnt_wr   = wr & mcnt_hit;
  wire [15:0] mcnt_wval = lane_merge(mload_ff, dat_i, sel_i);

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge clk_i) begin
    sync1_ff <= rst_i ? ZERO8 : ch_pin_i;
    sync2_ff <= rst_i ? ZERO8 : sync1_ff;
    prev_ff  <= rst_i ? ZERO8 : sync2_ff;
  end
  wire [7:0] edge_raw = sync2_ff ^ prev_ff;

  // Edge delay filter per channel; a narrow pulse that returns is dropped
  // RQ17 delay filter count
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (rst_i) begin
        dcnt_ff[i] <= '0;
        dbusy_ff[i] <= 1'b0;
        dlvl_ff[i] <= 1'b0;
        fevt_ff[i] <= 1'b0;
        fpol_ff[i] <= 1'b0;
      end else if (dly_sel_ff == 2'b00) begin
        dbusy_ff[i] <= 1'b0;
        fevt_ff[i] <= edge_raw[i];
        fpol_ff[i] <= sync2_ff[i];
      end else if (dbusy_ff[i]) begin
        fevt_ff[i] <= 1'b0;
        dcnt_ff[i] <= dcnt_ff[i] + 11'h001;
        if (dcnt_ff[i] == dly_len(dly_sel_ff) - 11'h001) begin
          dcnt_ff[i] <= '0;
          dbusy_ff[i] <= 1'b0;
          fevt_ff[i] <= (sync2_ff[i] != dlvl_ff[i]);
          fpol_ff[i] <= sync2_ff[i];
        end
      end else begin
        fevt_ff[i] <= 1'b0;
        dbusy_ff[i] <= edge_raw[i];
        dlvl_ff[i] <= prev_ff[i];
        dcnt_ff[i] <= '0;
      end
    end
  end

  // RQ20 channel sharing
  wire [7:0] evt = {fevt_ff[7:4] | (fevt_ff[3:0] & csys_ff.channel_share), fevt_ff[3:0]};
  assign capture_event_o = evt;

  // Pulse accumulator increments
  // RQ3 selected edge or trailing gate edge
  wire a_sel_edge = edge_raw[7] & (sync2_ff[7] == a_edge);
  wire a_inc      = a_gated ? (gate_tick_i & (sync2_ff[7] != a_edge)) : a_sel_edge;
  wire [15:0] pair_a = {pac_ff[3], pac_ff[2]};
  wire [15:0] pair_b = {pac_ff[1], pac_ff[0]};
  // RQ16 individual enables gated by system enables
  wire [3:0] byte_inc = {~a_en & acc_en_ff[3] & evt[3], ~a_en & acc_en_ff[2] & evt[2],
                         ~b_en & acc_en_ff[1] & evt[1], ~b_en & acc_en_ff[0] & evt[0]};
  // RQ2 accumulator A overflow sources
  wire a_ovf_set = (a_en & a_inc & (pair_a == MOD_PRESET)) |
                   (byte_inc[3] & (pac_ff[3] == FULL8) & ~csys_ff.max_count);
  // RQ6 accumulator B overflow sources
  wire b_ovf_set = (b_en & evt[0] & (pair_b == MOD_PRESET)) |
                   (byte_inc[1] & (pac_ff[1] == FULL8) & ~csys_ff.max_count);

  // Modulus down-counter control
  wire [4:0] rate_cur = div_rate(mctl_ff.presc_sel);
  wire mtick     = mctl_ff.enable & ({1'b0, pcnt_ff} == rate_ff - 5'h01);
  // RQ14 zero reached by counting; a written zero does not flag
  wire underflow = mtick & (mcnt_ff == 16'h0001);
  wire fload     = wr_b0 & (idx == IDX_MOD_CTL) & dat_i[3] & mctl_ff.enable;
  // RQ10 latch triggers
  wire flatch    = wr_b0 & (idx == IDX_MOD_CTL) & dat_i[4];
  wire latch_evt = latch_md & (flatch | underflow | (mcnt_wr & (mcnt_wval == ZERO16)));

  // Next accumulator values: counting, then latch clear, then bus writes
  // RQ4 cascaded A pair, RQ6 cascaded B pair
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_pac[i] = pac_ff[i];
      if (byte_inc[i] && !(csys_ff.max_count && pac_ff[i] == FULL8)) begin
        nxt_pac[i] = pac_ff[i] + 8'h01;
      end
    end
    if (a_en && a_inc) begin
      {nxt_pac[3], nxt_pac[2]} = pair_a + 16'h0001;
    end
    if (b_en && evt[0]) begin
      {nxt_pac[1], nxt_pac[0]} = pair_b + 16'h0001;
    end
    if (latch_evt) begin
      for (int i = 0; i < 4; i++) begin
        nxt_pac[i] = ZERO8;
      end
    end
    // RQ5 whole-word pair write in one access
    if (wr && idx == IDX_ACC_A_PAIR) begin
      {nxt_pac[3], nxt_pac[2]} = lane_merge(pair_a, dat_i, sel_i);
    end
    if (wr && idx == IDX_ACC_B_PAIR) begin
      {nxt_pac[1], nxt_pac[0]} = lane_merge(pair_b, dat_i, sel_i);
    end
    for (int i = 0; i < 4; i++) begin
      if (wr_b0 && idx == IDX_ACC0_COUNT - 8'(i)) begin
        nxt_pac[i] = dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      pac_ff[i] <= rst_i ? ZERO8 : nxt_pac[i];
    end
  end

  // Accumulator flags; a hardware set wins over any clear in the same cycle
  // RQ1 fast clear of A flags, RQ2 and RQ3 write-one clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_ovf_ff <= 1'b0;
      a_in_ff  <= 1'b0;
      b_ovf_ff <= 1'b0;
    end else begin
      a_ovf_ff <= a_ovf_set | (a_ovf_ff & ~(fast_clr & acc_a_hit) &
                  ~(wr_b0 & idx == IDX_ACC_A_FLAGS & dat_i[BIT_OVF]));
      a_in_ff  <= (a_en & a_sel_edge) | (a_in_ff & ~(fast_clr & acc_a_hit) &
                  ~(wr_b0 & idx == IDX_ACC_A_FLAGS & dat_i[BIT_IN_FLAG]));
      b_ovf_ff <= b_ovf_set | (b_ovf_ff & ~(fast_clr & acc_b_hit) &
                  ~(wr_b0 & idx == IDX_ACC_B_FLAGS & dat_i[BIT_OVF]));
    end
  end

  // Down-counter; rate is refreshed while disabled and whenever a new count is loaded
  // RQ7 one-shot or reload, RQ11 force load, RQ12 preset while disabled, RQ13 rate
  always_ff @(posedge clk_i) begin
    if (rst_i || !mctl_ff.enable) begin
      mcnt_ff <= MOD_PRESET;
      pcnt_ff <= '0;
      rate_ff <= rst_i ? DIV_CODE_0 : rate_cur;
    end else if (fload) begin
      mcnt_ff <= mload_ff;
      pcnt_ff <= '0;
      rate_ff <= rate_cur;
    end else if (mcnt_wr && (!mctl_ff.reload_mode || mcnt_wval == ZERO16)) begin
      mcnt_ff <= mcnt_wval;
      pcnt_ff <= '0;
      rate_ff <= rate_cur;
    end else if (mcnt_ff != ZERO16) begin
      pcnt_ff <= mtick ? 4'h0 : pcnt_ff + 4'h1;
      if (mtick && underflow && mctl_ff.reload_mode) begin
        mcnt_ff <= mload_ff;
        rate_ff <= rate_cur;
      end else if (mtick) begin
        mcnt_ff <= mcnt_ff - 16'h0001;
      end
    end
  end

  // Underflow flag: set wins over write-one and fast clear
  // RQ14 underflow flag and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uflag_ff <= 1'b0;
    end else begin
      uflag_ff <= underflow | (uflag_ff & ~(fast_clr & mcnt_hit) &
                  ~(wr_b0 & idx == IDX_MOD_FLAGS & dat_i[BIT_UNDERFLOW]));
    end
  end
  assign underflow_irq_o = uflag_ff & mctl_ff.irq_en;

  // Control registers; force bits are strobes and never stored
  // RQ19 one write in normal mode, RQ23 reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mctl_ff <= '0;
      csys_ff <= '0;
      auxctl_ff <= ZERO8;
      acc_en_ff <= ZERO8;
      novw_ff <= ZERO8;
      dly_sel_ff <= 2'b00;
      sys_written_ff <= 1'b0;
      mload_ff <= ZERO16;
    end else begin
      if (wr_b0 && idx == IDX_MOD_CTL) begin
        mctl_ff <= ctm_modctl_t'({dat_i[7:5], 2'b00, dat_i[2:0]});
      end
      if (wr_b0 && idx == IDX_CAP_SYS_CTL && !(normal_mode_i && sys_written_ff)) begin
        csys_ff <= ctm_capsys_t'(dat_i[7:0]);
        sys_written_ff <= 1'b1;
      end
      if (wr_b0 && idx == IDX_AUX_CTL) begin
        auxctl_ff <= {3'b000, dat_i[4:0]};
      end
      if (wr_b0 && idx == IDX_ACC_EN_CTL) begin
        acc_en_ff <= {4'h0, dat_i[3:0]};
      end
      if (wr_b0 && idx == IDX_NO_OVW_CTL) begin
        novw_ff <= dat_i[7:0];
      end
      if (wr_b0 && idx == IDX_DELAY_CTL) begin
        dly_sel_ff <= dat_i[1:0];
      end
      if (mcnt_wr) begin
        mload_ff <= mcnt_wval;
      end
    end
  end
  assign mod_ctl_o = mctl_ff;

  // Capture channels 0..3 with holding registers
  // RQ18 no-overwrite, RQ21 flag timing, RQ22 queue transfer, RQ15 polarity
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i) begin
        cap_ff[i] <= ZERO16;
        hold_ff[i] <= ZERO16;
        pach_ff[i] <= ZERO8;
        cap_full_ff[i] <= 1'b0;
        hold_full_ff[i] <= 1'b0;
        pol_ff[i] <= 1'b0;
        pol_arm_ff[i] <= 1'b1;
        cflag_ff[i] <= 1'b0;
      end else begin
        if (rd && idx == IDX_CAPTURE0 + 8'(i)) begin
          cap_full_ff[i] <= 1'b0;
        end
        if (rd && idx == IDX_HOLD0 + 8'(i)) begin
          hold_full_ff[i] <= 1'b0;
          pol_arm_ff[i] <= 1'b1;
        end
        if (wr_b0 && idx == IDX_CAP_FLAGS && dat_i[i]) begin
          cflag_ff[i] <= 1'b0;
        end
        if (latch_evt && (!novw_ff[i] || !hold_full_ff[i])) begin
          hold_ff[i] <= cap_ff[i];
          pach_ff[i] <= pac_ff[i];
          hold_full_ff[i] <= 1'b1;
          cap_full_ff[i] <= 1'b0;
        end else if (evt[i]) begin
          if (pol_arm_ff[i]) begin
            pol_ff[i] <= fpol_ff[i];
            pol_arm_ff[i] <= 1'b0;
          end
          if (queue_md && cap_full_ff[i]) begin
            if (!novw_ff[i] || !hold_full_ff[i]) begin
              hold_ff[i] <= cap_ff[i];
              hold_full_ff[i] <= 1'b1;
              cap_ff[i] <= timer_i;
              cflag_ff[i] <= 1'b1;
            end
          end else if (!novw_ff[i] || !cap_full_ff[i]) begin
            cap_ff[i] <= timer_i;
            cap_full_ff[i] <= 1'b1;
            if (!(queue_md && csys_ff.flag_timing_mode)) begin
              cflag_ff[i] <= 1'b1;
            end
          end
        end
      end
    end
  end
  assign capture_flags_o = cflag_ff;

  // Read mux; unmapped indices answer zero
  // RQ9 live count or load register
  wire [15:0] mcnt_rd = mctl_ff.read_load ? mload_ff : mcnt_ff;
  wire [1:0]  csel    = idx[1:0];
  wire [15:0] rmux =
    (idx == IDX_ACC_A_FLAGS) ? {14'h0000, a_ovf_ff, a_in_ff} :
    (idx == IDX_ACC_B_FLAGS) ? {14'h0000, b_ovf_ff, 1'b0} :
    (idx == IDX_ACC3_COUNT)  ? {8'h00, pac_ff[3]} :
    (idx == IDX_ACC2_COUNT)  ? {8'h00, pac_ff[2]} :
    (idx == IDX_ACC1_COUNT)  ? {8'h00, pac_ff[1]} :
    (idx == IDX_ACC0_COUNT)  ? {8'h00, pac_ff[0]} :
    // RQ10 force bits read zero
    (idx == IDX_MOD_CTL)     ? {8'h00, mctl_ff.irq_en, mctl_ff.reload_mode,
                                mctl_ff.read_load, 2'b00, mctl_ff.enable,
                                mctl_ff.presc_sel} :
    (idx == IDX_MOD_FLAGS)   ? {8'h00, uflag_ff, 3'b000, pol_ff} :
    (idx == IDX_ACC_EN_CTL)  ? {8'h00, acc_en_ff} :
    (idx == IDX_DELAY_CTL)   ? {14'h0000, dly_sel_ff} :
    (idx == IDX_NO_OVW_CTL)  ? {8'h00, novw_ff} :
    (idx == IDX_CAP_SYS_CTL) ? {8'h00, csys_ff} :
    (idx == IDX_MOD_COUNT)   ? mcnt_rd :
    (idx == IDX_ACC_A_PAIR)  ? pair_a :
    (idx == IDX_ACC_B_PAIR)  ? pair_b :
    (idx == IDX_AUX_CTL)     ? {8'h00, auxctl_ff} :
    (idx == IDX_CAP_FLAGS)   ? {12'h000, cflag_ff} :
    (idx[7:2] == IDX_CAPTURE0[7:2]) ? cap_ff[csel] :
    (idx[7:2] == IDX_HOLD0[7:2])    ? hold_ff[csel] :
    (idx[7:2] == IDX_ACC_HOLD0[7:2]) ? {8'h00, pach_ff[csel]} : ZERO16;

  // Ack one cycle after the request; drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    ack_ff   <= ~rst_i & req;
    rdata_ff <= rst_i ? 32'h0000_0000 : (rd ? {16'h0000, rmux} : 32'h0000_0000);
  end
  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  // Checks
  sequence s_mcnt_read_live;
    rd && idx == IDX_MOD_COUNT && !mctl_ff.read_load;
  endsequence
  chk_preset_when_off: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
    !mctl_ff.enable |=> mcnt_ff == MOD_PRESET) else $error("count not preset");
  chk_acc_a_overflow: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    a_ovf_set |=> a_ovf_ff) else $error("A overflow lost");
  chk_acc_a_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    a_en && a_sel_edge |=> a_in_ff) else $error("A input flag lost");
  chk_force_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    rd && idx == IDX_MOD_CTL |=> ack_o && dat_o[4:3] == 2'b00)
    else $error("force bits read nonzero");
  chk_underflow_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
    underflow |=> uflag_ff ##0 (underflow_irq_o == mctl_ff.irq_en))
    else $error("underflow flag or irq wrong");
  chk_delay_length: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    $fell(dbusy_ff[0]) && dly_sel_ff != 2'b00 && $stable(dly_sel_ff)
    |-> $past(dcnt_ff[0]) == dly_len(dly_sel_ff) - 11'h001)
    else $error("delay length wrong");
  chk_sys_write_once: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
    wr && idx == IDX_CAP_SYS_CTL && normal_mode_i && sys_written_ff
    |=> $stable(csys_ff)) else $error("capture system register rewritten");
  chk_count_read_live: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
    s_mcnt_read_live |=> dat_o[15:0] == $past(mcnt_ff)) else $error("live count read wrong");
  chk_share_path: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
    edge_raw[1] && csys_ff.channel_share[1] && dly_sel_ff == 2'b00 |=> capture_event_o[5])
    else $error("shared event missing");
endmodule

// [hw/ctm_pkg.sv]
// Purpose: Shared constants and carrier types for the capture timer support block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Bit positions and reset values live here only
package ctm_pkg;
  // Register word indices
  localparam logic [7:0] IDX_ACC_A_FLAGS = 8'h00a1;
  localparam logic [7:0] IDX_ACC3_COUNT  = 8'h00a2;
  localparam logic [7:0] IDX_ACC2_COUNT  = 8'h00a3;
  localparam logic [7:0] IDX_ACC1_COUNT  = 8'h00a4;
  localparam logic [7:0] IDX_ACC0_COUNT  = 8'h00a5;
  localparam logic [7:0] IDX_MOD_CTL     = 8'h00a6;
  localparam logic [7:0] IDX_MOD_FLAGS   = 8'h00a7;
  localparam logic [7:0] IDX_ACC_EN_CTL  = 8'h00a8;
  localparam logic [7:0] IDX_DELAY_CTL   = 8'h00a9;
  localparam logic [7:0] IDX_NO_OVW_CTL  = 8'h00aa;
  localparam logic [7:0] IDX_CAP_SYS_CTL = 8'h00ab;
  localparam logic [7:0] IDX_MOD_COUNT   = 8'h00ac;
  localparam logic [7:0] IDX_ACC_A_PAIR  = 8'h00ad;
  localparam logic [7:0] IDX_ACC_B_PAIR  = 8'h00ae;
  localparam logic [7:0] IDX_AUX_CTL     = 8'h00af;
  localparam logic [7:0] IDX_ACC_B_FLAGS = 8'h00b1;
  localparam logic [7:0] IDX_CAPTURE0    = 8'h00c0;
  localparam logic [7:0] IDX_HOLD0       = 8'h00c4;
  localparam logic [7:0] IDX_ACC_HOLD0   = 8'h00c8;
  localparam logic [7:0] IDX_CAP_FLAGS   = 8'h00cc;
  // Field positions
  localparam int unsigned BIT_OVF        = 1;
  localparam int unsigned BIT_IN_FLAG    = 0;
  localparam int unsigned BIT_UNDERFLOW  = 7;
  localparam int unsigned BIT_FAST_CLR   = 0;
  localparam int unsigned BIT_A_ENABLE   = 1;
  localparam int unsigned BIT_B_ENABLE   = 2;
  localparam int unsigned BIT_A_GATED    = 3;
  localparam int unsigned BIT_A_EDGE     = 4;
  // Reset and fixed values
  localparam logic [15:0] MOD_PRESET     = 16'hffff;
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [7:0]  ZERO8          = 8'h00;
  localparam logic [7:0]  FULL8          = 8'hff;
  // Delay filter lengths in module clocks
  localparam logic [10:0] DLY_CYC_1      = 11'h0100;
  localparam logic [10:0] DLY_CYC_2      = 11'h0200;
  localparam logic [10:0] DLY_CYC_3      = 11'h0400;
  // Modulus prescaler division rates
  localparam logic [4:0]  DIV_CODE_0     = 5'h01;
  localparam logic [4:0]  DIV_CODE_1     = 5'h04;
  localparam logic [4:0]  DIV_CODE_2     = 5'h08;
  localparam logic [4:0]  DIV_CODE_3     = 5'h10;

  typedef struct packed {
    logic       irq_en;
    logic       reload_mode;
    logic       read_load;
    logic       force_latch;
    logic       force_load;
    logic       enable;
    logic [1:0] presc_sel;
  } ctm_modctl_t;

  typedef struct packed {
    logic [3:0] channel_share;
    logic       flag_timing_mode;
    logic       max_count;
    logic       holding_buffer_enable;
    logic       latch_or_queue_select;
  } ctm_capsys_t;
endpackage
